// [core/occ_pkg.sv]
// Shared constants and types of the output clock and sync control block
package occ_pkg;
   localparam int OCC_DW = 12;
   localparam int OCC_AW = 8;
   // Register indices; byte address is four times the index
   localparam logic [OCC_AW-1:0] OCC_IDX_CTRL = 8'h00;
   localparam logic [OCC_AW-1:0] OCC_IDX_PHASE = 8'h0E;
   localparam logic [OCC_AW-1:0] OCC_IDX_STAT = 8'h0F;
   localparam logic [OCC_AW-1:0] OCC_ADDR_CTRL = 8'(OCC_IDX_CTRL * 4);
   localparam logic [OCC_AW-1:0] OCC_ADDR_PHASE = 8'(OCC_IDX_PHASE * 4);
   localparam logic [OCC_AW-1:0] OCC_ADDR_STAT = 8'(OCC_IDX_STAT * 4);
   // Control register fields
   localparam int OCC_CTRL_ECM = 0;
   localparam int OCC_CTRL_DEMUX = 1;
   localparam int OCC_CTRL_DCC = 2;
   localparam int OCC_CTRL_LFS = 8;
   // Phase register fields
   localparam int OCC_PH_RSTEN = 0;
   localparam int OCC_PH_SEL_LO = 3;
   localparam int OCC_PH_SEL_HI = 4;
   // Status register fields
   localparam int OCC_ST_HOLD = 0;
   localparam int OCC_ST_RUN = 1;
   localparam int OCC_ST_PRIMED = 2;
   localparam int OCC_ST_QPD = 3;
   // Reset values
   localparam logic OCC_ECM_RST = 1'b0;
   localparam logic OCC_DEMUX_RST = 1'b1;
   localparam logic OCC_DCC_RST = 1'b1;
   localparam logic OCC_LFS_RST = 1'b0;
   localparam logic OCC_RSTEN_RST = 1'b0;
   localparam logic [1:0] OCC_PHSEL_RST = 2'h0;
   // Sampling clock cycle counts
   localparam logic [2:0] OCC_SYNC_DLY_90 = 3'h4;
   localparam logic [2:0] OCC_SYNC_DLY_0 = 3'h5;
   localparam logic [2:0] OCC_RESTART_DLY = 3'h2;
   localparam logic [2:0] OCC_CNT_ONE = 3'h1;
   typedef enum logic [1:0] {OCC_RUN, OCC_HOLD, OCC_DELAY, OCC_RESTART} occ_state_t;
endpackage

// [core/occ_clk_engine.sv]
// Output clock generator with reset-driven realignment, sampling clock domain
`timescale 1ns/1ns
module occ_clk_engine
   import occ_pkg::*;
(
   input wire logic smp_clk,
   input wire logic smp_rst_n,
   input wire logic enable,
   input wire logic demux,
   input wire logic phase90,
   input wire logic rst_req,
   output logic oclk_ff,
   output logic slot_ff,
   output logic hold,
   output logic running,
   output logic primed_ff
);
   occ_state_t state_ff;
   logic [2:0] cnt_ff;
   logic sync_edge;
   logic restart_edge;
   logic toggle;

   assign sync_edge = (state_ff == OCC_DELAY) && (cnt_ff == 3'h0);
   assign restart_edge = (state_ff == OCC_RESTART) && (cnt_ff == 3'h0);
   assign hold = (state_ff != OCC_RUN);
   assign running = (state_ff == OCC_RUN);
   // Demux: one clock edge per sample pair
   assign toggle = demux ? slot_ff : 1'b1;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_ff @(posedge smp_clk or negedge smp_rst_n) begin
      if (!smp_rst_n) begin
         state_ff <= OCC_RUN;
         cnt_ff <= 3'h0;
      end else begin
         case (state_ff)
            OCC_RUN: begin
               if (enable && rst_req) begin
                  state_ff <= OCC_HOLD;
               end
            end
            OCC_HOLD: begin
               if (!rst_req) begin
                  state_ff <= OCC_DELAY;
                  cnt_ff <= (phase90 ? OCC_SYNC_DLY_90 : OCC_SYNC_DLY_0) - OCC_CNT_ONE;
               end
            end
            OCC_DELAY: begin
               if (sync_edge) begin
                  state_ff <= OCC_RESTART;
                  cnt_ff <= OCC_RESTART_DLY - OCC_CNT_ONE;
               end else begin
                  cnt_ff <= cnt_ff - OCC_CNT_ONE;
               end
            end
            OCC_RESTART: begin
               if (restart_edge) begin
                  state_ff <= OCC_RUN;
               end else begin
                  cnt_ff <= cnt_ff - OCC_CNT_ONE;
               end
            end
            default: begin
               state_ff <= OCC_RUN;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Clock and slot
   // ------------------------------------------------------------
   // Restarting from a fixed phase makes every converter leave alike
   always_ff @(posedge smp_clk or negedge smp_rst_n) begin
      if (!smp_rst_n) begin
         oclk_ff <= 1'b0;
         slot_ff <= 1'b0;
      end else if (restart_edge) begin
         oclk_ff <= 1'b0;
         slot_ff <= 1'b0;
      end else if (hold && demux) begin
         oclk_ff <= 1'b1;
         slot_ff <= 1'b0;
      end else begin
         slot_ff <= ~slot_ff;
         if (toggle) begin
            oclk_ff <= ~oclk_ff;
         end
      end
   end

   // First pulse after power-up leaves exit state unknown; flag when primed
   always_ff @(posedge smp_clk or negedge smp_rst_n) begin
      if (!smp_rst_n) begin
         primed_ff <= 1'b0;
      end else if (restart_edge) begin
         primed_ff <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_hold_high: assert property (@(posedge smp_clk) disable iff (!smp_rst_n)
      (state_ff == OCC_HOLD) && demux |=> oclk_ff)
      else $error("output clock not held high during reset");
   chk_sync_edge90: assert property (@(posedge smp_clk) disable iff (!smp_rst_n)
      (state_ff == OCC_HOLD) && !rst_req && phase90 |=> ##3 sync_edge)
      else $error("sync edge not four cycles after release");
   chk_sync_edge0: assert property (@(posedge smp_clk) disable iff (!smp_rst_n)
      (state_ff == OCC_HOLD) && !rst_req && !phase90 |=> ##4 sync_edge)
      else $error("sync edge not five cycles after release");
   chk_restart_fixed: assert property (@(posedge smp_clk) disable iff (!smp_rst_n)
      sync_edge |=> ##1 restart_edge ##1 (running && !oclk_ff))
      else $error("clock restart delay not constant");
   chk_disabled_ignore: assert property (@(posedge smp_clk) disable iff (!smp_rst_n)
      running && !enable |=> running)
      else $error("reset input acted while disabled");
   cov_demux_sync: cover property (@(posedge smp_clk) disable iff (!smp_rst_n)
      demux && sync_edge ##2 running);
   cov_nodemux_sync: cover property (@(posedge smp_clk) disable iff (!smp_rst_n)
      !demux && sync_edge ##2 running);
endmodule

// [core/occ_top.sv]
// Output clock, bus usage and clock-reset control with APB registers
// Functional notes
// - Duty-cycle correction is enabled out of reset.
// - Output samples leave at the same overall rate as sampled.
// - Demux mode drives both 12-bit buses; one bus alone gives half rate.
// - Non-demux mode: only primary buses valid, delayed buses undriven.
// - Q powerdown leaves Q bus, Q clock and Q out-of-range undriven.
// - No automatic multi-device sync; only the clock reset exists.
// - Clock reset is off after reset; enabled only in extended control mode.
// - I and Q output clocks are always identical.
// - During reset, clock held high in demux; toggles on in non-demux.
// - A single narrow clock pulse at reset assertion must be tolerated.
// - Sync edge 4 cycles after release in 90 degree mode, 5 in 0 degree.
// - Clock restarts a fixed delay after the sync edge.
`timescale 1ns/1ns
module occ_top
   import occ_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [OCC_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic smp_clk,
   input wire logic output_clock_reset,
   input wire logic q_channel_powerdown,
   input wire logic [OCC_DW-1:0] i_sample,
   input wire logic [OCC_DW-1:0] q_sample,
   input wire logic i_ovr,
   input wire logic q_ovr,
   output logic low_rate_clock_select,
   output logic dcc_enable,
   output logic i_output_clock,
   output logic q_output_clock,
   output logic q_clock_oe,
   output logic [OCC_DW-1:0] i_primary_bus,
   output logic [OCC_DW-1:0] i_delayed_bus,
   output logic [OCC_DW-1:0] q_primary_bus,
   output logic [OCC_DW-1:0] q_delayed_bus,
   output logic q_primary_oe,
   output logic i_delayed_oe,
   output logic q_delayed_oe,
   output logic i_out_of_range,
   output logic q_out_of_range,
   output logic q_ovr_oe
);
   logic ecm_ff;
   logic demux_ff;
   logic dcc_ff;
   logic lfs_ff;
   logic rsten_ff;
   logic [1:0] phsel_ff;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_rdata;
   logic wr_en;
   logic rd_setup;
   logic hit;
   // Sampling-domain crossings
   logic [1:0] srst_ff;
   logic smp_rst_n;
   logic [3:0] cfg_s1_ff;
   logic [3:0] cfg_s2_ff;
   logic [1:0] pin_s1_ff;
   logic [1:0] pin_s2_ff;
   logic [3:0] st_src_ff;
   logic [3:0] st_s1_ff;
   logic [3:0] st_s2_ff;
   logic en_s;
   logic demux_s;
   logic ph90_s;
   logic rstreq_s;
   logic pdq_s;
   // Engine
   logic oclk;
   logic slot;
   logic hold;
   logic running;
   logic primed;
   // Data path
   logic [OCC_DW-1:0] i_hold_ff;
   logic [OCC_DW-1:0] q_hold_ff;
   logic [OCC_DW-1:0] i_pri_ff;
   logic [OCC_DW-1:0] i_del_ff;
   logic [OCC_DW-1:0] q_pri_ff;
   logic [OCC_DW-1:0] q_del_ff;
   logic i_or_ff;
   logic q_or_ff;

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   // Zero wait states; a low clock enable stretches the access
   assign pready = pce;
   assign hit = (paddr == OCC_ADDR_CTRL) || (paddr == OCC_ADDR_PHASE) || (paddr == OCC_ADDR_STAT);
   assign pslverr = psel && penable && !hit;
   assign wr_en = psel && penable && pwrite && pce && hit;
   assign rd_setup = psel && !penable && !pwrite && pce;
   assign prdata = prdata_ff;

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      case (paddr)
         OCC_ADDR_CTRL: begin
            nxt_rdata[OCC_CTRL_ECM] = ecm_ff;
            nxt_rdata[OCC_CTRL_DEMUX] = demux_ff;
            nxt_rdata[OCC_CTRL_DCC] = dcc_ff;
            nxt_rdata[OCC_CTRL_LFS] = lfs_ff;
         end
         OCC_ADDR_PHASE: begin
            nxt_rdata[OCC_PH_RSTEN] = rsten_ff;
            nxt_rdata[OCC_PH_SEL_HI:OCC_PH_SEL_LO] = phsel_ff;
         end
         OCC_ADDR_STAT: begin
            nxt_rdata[OCC_ST_HOLD] = st_s2_ff[0];
            nxt_rdata[OCC_ST_RUN] = st_s2_ff[1];
            nxt_rdata[OCC_ST_PRIMED] = st_s2_ff[2];
            nxt_rdata[OCC_ST_QPD] = st_s2_ff[3];
         end
         default: begin
            nxt_rdata = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata_ff <= nxt_rdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ecm_ff <= OCC_ECM_RST;
         demux_ff <= OCC_DEMUX_RST;
         dcc_ff <= OCC_DCC_RST;
         lfs_ff <= OCC_LFS_RST;
      end else if (wr_en && (paddr == OCC_ADDR_CTRL)) begin
         ecm_ff <= pwdata[OCC_CTRL_ECM];
         demux_ff <= pwdata[OCC_CTRL_DEMUX];
         dcc_ff <= pwdata[OCC_CTRL_DCC];
         lfs_ff <= pwdata[OCC_CTRL_LFS];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsten_ff <= OCC_RSTEN_RST;
         phsel_ff <= OCC_PHSEL_RST;
      end else if (wr_en && (paddr == OCC_ADDR_PHASE)) begin
         rsten_ff <= pwdata[OCC_PH_RSTEN];
         phsel_ff <= pwdata[OCC_PH_SEL_HI:OCC_PH_SEL_LO];
      end
   end

   assign low_rate_clock_select = lfs_ff;
   assign dcc_enable = dcc_ff;

   // Registered at the source so a glitching state decode never reaches the synchronizer
   always_ff @(posedge smp_clk or negedge smp_rst_n) begin
      if (!smp_rst_n) begin
         st_src_ff <= 4'h0;
      end else begin
         st_src_ff <= {pdq_s, primed, running, hold};
      end
   end

   // Status back into the bus domain; levels only, so two flops suffice
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_s1_ff <= 4'h0;
         st_s2_ff <= 4'h0;
      end else if (pce) begin
         st_s1_ff <= st_src_ff;
         st_s2_ff <= st_s1_ff;
      end
   end

   // ------------------------------------------------------------
   // Sampling clock domain crossings
   // ------------------------------------------------------------
   always_ff @(posedge smp_clk or negedge presetn) begin
      if (!presetn) begin
         srst_ff <= 2'h0;
      end else begin
         srst_ff <= {srst_ff[0], 1'b1};
      end
   end
   assign smp_rst_n = srst_ff[1];

   // Quasi-static configuration; a change mid-frame may cost one sample pair
   always_ff @(posedge smp_clk or negedge smp_rst_n) begin
      if (!smp_rst_n) begin
         cfg_s1_ff <= 4'h0;
         cfg_s2_ff <= 4'h0;
      end else begin
         cfg_s1_ff <= {phsel_ff[0], demux_ff, ecm_ff && rsten_ff, 1'b0};
         cfg_s2_ff <= cfg_s1_ff;
      end
   end
   assign en_s = cfg_s2_ff[1];
   assign demux_s = cfg_s2_ff[2];
   assign ph90_s = cfg_s2_ff[3];

   // Pins may change at any time against the sampling clock
   always_ff @(posedge smp_clk or negedge smp_rst_n) begin
      if (!smp_rst_n) begin
         pin_s1_ff <= 2'h0;
         pin_s2_ff <= 2'h0;
      end else begin
         pin_s1_ff <= {q_channel_powerdown, output_clock_reset};
         pin_s2_ff <= pin_s1_ff;
      end
   end
   assign rstreq_s = pin_s2_ff[0];
   assign pdq_s = pin_s2_ff[1];

   // ------------------------------------------------------------
   // Output clock engine
   // ------------------------------------------------------------
   // Only the clock reset realigns; there is no automatic sync
   occ_clk_engine u_engine (
      .smp_clk(smp_clk),
      .smp_rst_n(smp_rst_n),
      .enable(en_s),
      .demux(demux_s),
      .phase90(ph90_s),
      .rst_req(rstreq_s),
      .oclk_ff(oclk),
      .slot_ff(slot),
      .hold(hold),
      .running(running),
      .primed_ff(primed)
   );

   // One flop feeds both clocks so they can never drift apart
   assign i_output_clock = oclk;
   assign q_output_clock = oclk;
   // Synchronized clock cannot glitch, but reset entry in demux can cut one low phase to one cycle
   assign q_clock_oe = !pdq_s;

   // ------------------------------------------------------------
   // Data path
   // ------------------------------------------------------------
   always_ff @(posedge smp_clk or negedge smp_rst_n) begin
      if (!smp_rst_n) begin
         i_hold_ff <= '0;
         q_hold_ff <= '0;
      end else if (!slot) begin
         i_hold_ff <= i_sample;
         q_hold_ff <= q_sample;
      end
   end

   always_ff @(posedge smp_clk or negedge smp_rst_n) begin
      if (!smp_rst_n) begin
         i_pri_ff <= '0;
         i_del_ff <= '0;
         q_pri_ff <= '0;
         q_del_ff <= '0;
      end else if (!demux_s) begin
         i_pri_ff <= i_sample;
         q_pri_ff <= q_sample;
         i_del_ff <= '0;
         q_del_ff <= '0;
      end else if (slot) begin
         i_pri_ff <= i_sample;
         q_pri_ff <= q_sample;
         i_del_ff <= i_hold_ff;
         q_del_ff <= q_hold_ff;
      end
   end

   always_ff @(posedge smp_clk or negedge smp_rst_n) begin
      if (!smp_rst_n) begin
         i_or_ff <= 1'b0;
         q_or_ff <= 1'b0;
      end else begin
         i_or_ff <= i_ovr;
         q_or_ff <= q_ovr;
      end
   end

   assign i_primary_bus = i_pri_ff;
   assign i_delayed_bus = i_del_ff;
   assign q_primary_bus = q_pri_ff;
   assign q_delayed_bus = q_del_ff;
   assign i_out_of_range = i_or_ff;
   assign q_out_of_range = q_or_ff;
   assign i_delayed_oe = demux_s;
   assign q_primary_oe = !pdq_s;
   assign q_delayed_oe = demux_s && !pdq_s;
   assign q_ovr_oe = !pdq_s;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_dcc_default: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> dcc_enable)
      else $error("duty-cycle correction off after reset");
   chk_clkrst_off: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> !(ecm_ff && rsten_ff))
      else $error("clock reset enabled after reset");
   chk_rate_nodemux: assert property (@(posedge smp_clk) disable iff (!smp_rst_n)
      !demux_s ##1 !demux_s ##1 !demux_s |-> i_primary_bus == $past(i_sample))
      else $error("non-demux output lags sample rate");
   chk_demux_pair: assert property (@(posedge smp_clk) disable iff (!smp_rst_n)
      demux_s && slot |=> i_primary_bus == $past(i_sample) && i_delayed_bus == $past(i_hold_ff))
      else $error("demux pair not delivered");
   chk_delayed_hiz: assert property (@(posedge smp_clk) disable iff (!smp_rst_n)
      !demux_s ##1 !demux_s |-> !i_delayed_oe && !q_delayed_oe && i_delayed_bus == '0 && q_delayed_bus == '0)
      else $error("delayed bus driven in non-demux");
   chk_q_unused: assert property (@(posedge smp_clk) disable iff (!smp_rst_n)
      pdq_s |-> !q_primary_oe && !q_clock_oe && !q_ovr_oe && !q_delayed_oe)
      else $error("Q outputs driven while powered down");
   chk_iq_aligned: assert property (@(posedge smp_clk) disable iff (!smp_rst_n)
      i_output_clock == q_output_clock)
      else $error("I and Q output clocks differ");
   chk_nodemux_toggle: assert property (@(posedge smp_clk) disable iff (!smp_rst_n)
      hold && rstreq_s && !demux_s && $past(!demux_s) |=> i_output_clock != $past(i_output_clock))
      else $error("non-demux clock stopped in reset");
   cov_qpd: cover property (@(posedge smp_clk) disable iff (!smp_rst_n) pdq_s && demux_s);
endmodule

// [tb/occ_rx_model.sv]
// Receiver model: captures one output bus and drives the clock reset pin
`timescale 1ns/1ns
module occ_rx_model
   import occ_pkg::*;
(
   input wire logic smp_clk,
   input wire logic i_output_clock,
   input wire logic [OCC_DW-1:0] i_primary_bus,
   output logic output_clock_reset
);
   int words;
   logic [OCC_DW-1:0] last_word;

   initial begin
      output_clock_reset = 1'b0;
      words = 0;
      last_word = 12'h000;
   end

   // ----------------------------------------
   // Capture
   // ----------------------------------------
   // One bus only, so demux mode hands us every second sample
   always @(posedge i_output_clock) begin
      words <= words + 1;
      last_word <= i_primary_bus;
   end

   // ----------------------------------------
   // Reset pulses
   // ----------------------------------------
   // Moves just after a sampling edge: full width, setup and hold kept
   task automatic drive_pulse(input int width);
      @(posedge smp_clk);
      output_clock_reset <= 1'b1;
      repeat (width) @(posedge smp_clk);
      output_clock_reset <= 1'b0;
   endtask

   // First pulse after power-up leaves the exit state unknown; throw it away
   task automatic prime_pulse(input int width);
      drive_pulse(width);
      repeat (16) @(posedge smp_clk);
   endtask
endmodule

// [tb/tb.sv]
// Testbench: APB register access, output buses and clock reset alignment
`timescale 1ns/1ns
module tb
   import occ_pkg::*;
;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic pclk = 1'b0;
   logic smp_clk = 1'b0;
   logic presetn, pce, psel, penable, pwrite;
   logic [OCC_AW-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, output_clock_reset, q_channel_powerdown, i_ovr, q_ovr;
   logic [OCC_DW-1:0] i_sample, q_sample, i_primary_bus, i_delayed_bus, q_primary_bus, q_delayed_bus;
   logic low_rate_clock_select, dcc_enable, i_output_clock, q_output_clock, q_clock_oe;
   logic q_primary_oe, i_delayed_oe, q_delayed_oe, i_out_of_range, q_out_of_range, q_ovr_oe;
   int errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   int w0, d90, d_rep, d0;

   always #20 pclk = ~pclk;
   always #15 smp_clk = ~smp_clk;

   occ_top uut (
      .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .smp_clk(smp_clk), .output_clock_reset(output_clock_reset), .q_channel_powerdown(q_channel_powerdown),
      .i_sample(i_sample), .q_sample(q_sample), .i_ovr(i_ovr), .q_ovr(q_ovr),
      .low_rate_clock_select(low_rate_clock_select), .dcc_enable(dcc_enable),
      .i_output_clock(i_output_clock), .q_output_clock(q_output_clock), .q_clock_oe(q_clock_oe),
      .i_primary_bus(i_primary_bus), .i_delayed_bus(i_delayed_bus), .q_primary_bus(q_primary_bus),
      .q_delayed_bus(q_delayed_bus), .q_primary_oe(q_primary_oe), .i_delayed_oe(i_delayed_oe),
      .q_delayed_oe(q_delayed_oe), .i_out_of_range(i_out_of_range), .q_out_of_range(q_out_of_range),
      .q_ovr_oe(q_ovr_oe)
   );

   occ_rx_model rx (
      .smp_clk(smp_clk), .i_output_clock(i_output_clock), .i_primary_bus(i_primary_bus),
      .output_clock_reset(output_clock_reset)
   );

   // ----------------------------------------
   // Converter samples and watchdog
   // ----------------------------------------
   // Ramp data makes every lost or doubled sample visible as a wrong step
   always @(posedge smp_clk) begin
      i_sample <= i_sample + 12'h001;
      q_sample <= q_sample + 12'h001;
      i_ovr <= i_sample[1];
      q_ovr <= ~i_sample[1];
   end

   always @(negedge smp_clk) begin
      if (presetn === 1'b1) begin
         check({31'h0, i_output_clock}, {31'h0, q_output_clock});
      end
   end

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         errors++;
         tally_and_finish();
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [OCC_AW-1:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [OCC_AW-1:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd_chk(input logic [OCC_AW-1:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0000_0000, q, e);
      check(q, exp);
      check({31'h0, e}, {31'h0, exp_err});
   endtask

   task automatic bus_rate(input logic demux_mode);
      logic [OCC_DW-1:0] p0, p1;
      logic [1:0] ovr0;
      @(negedge smp_clk);
      p0 = i_primary_bus;
      ovr0 = {q_ovr, i_ovr};
      @(negedge smp_clk);
      p1 = i_primary_bus;
      check({30'h0, q_out_of_range, i_out_of_range}, {30'h0, ovr0});
      @(negedge smp_clk);
      check({20'h0, i_primary_bus - p0}, 32'h0000_0002);
      if (demux_mode) begin
         check({20'h0, i_primary_bus - i_delayed_bus}, 32'h0000_0001);
         check({20'h0, q_primary_bus - q_delayed_bus}, 32'h0000_0001);
      end else begin
         check({20'h0, p1 - p0}, 32'h0000_0001);
      end
   endtask

   // Clock must sit high while held, then fall at the restart edge
   task automatic pulse_gap(output int n);
      fork
         rx.drive_pulse(16);
         begin
            repeat (10) @(negedge smp_clk);
            check({31'h0, i_output_clock}, 32'h0000_0001);
         end
      join
      n = 0;
      do begin
         @(negedge smp_clk);
         n++;
      end while (i_output_clock !== 1'b0 && n < 40);
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      presetn = 1'b0;
      pce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      q_channel_powerdown = 1'b0;
      i_sample = 12'h000;
      q_sample = 12'h800;
      i_ovr = 1'b0;
      q_ovr = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(OCC_ADDR_CTRL, 32'h0000_0006, 1'b0);
      check({31'h0, dcc_enable}, 32'h0000_0001);
      rd_chk(OCC_ADDR_PHASE, 32'h0000_0000, 1'b0);
      rd_chk(8'h20, 32'h0000_0000, 1'b1);
      wr(OCC_ADDR_CTRL, 32'h0000_0106);
      rd_chk(OCC_ADDR_CTRL, 32'h0000_0106, 1'b0);
      check({31'h0, low_rate_clock_select}, 32'h0000_0001);
      wr(OCC_ADDR_PHASE, 32'h0000_0009);
      repeat (8) @(posedge smp_clk);
      check({31'h0, i_delayed_oe}, 32'h0000_0001);
      bus_rate(1'b1);
      w0 = rx.words;
      rx.drive_pulse(30);
      check({31'h0, (rx.words - w0) >= 6}, 32'h0000_0001);
      wr(OCC_ADDR_CTRL, 32'h0000_0107);
      rx.prime_pulse(12);
      pulse_gap(d90);
      pulse_gap(d_rep);
      check(32'(d_rep), 32'(d90));
      check({31'h0, d90 >= int'(OCC_SYNC_DLY_90 + OCC_RESTART_DLY)}, 32'h0000_0001);
      wr(OCC_ADDR_PHASE, 32'h0000_0001);
      pulse_gap(d0);
      check(32'(d0), 32'(d90 + 1));
      wr(OCC_ADDR_CTRL, 32'h0000_0105);
      repeat (8) @(posedge smp_clk);
      check({30'h0, i_delayed_oe, q_delayed_oe}, 32'h0000_0000);
      bus_rate(1'b0);
      w0 = rx.words;
      rx.drive_pulse(30);
      check({31'h0, (rx.words - w0) >= 12}, 32'h0000_0001);
      @(posedge smp_clk);
      q_channel_powerdown <= 1'b1;
      repeat (20) @(posedge smp_clk);
      check({28'h0, q_clock_oe, q_primary_oe, q_ovr_oe, q_delayed_oe}, 32'h0000_0000);
      rd_chk(OCC_ADDR_STAT, 32'h0000_000E, 1'b0);
      tally_and_finish();
   end
endmodule
